// ===== common/rpps_pkg.sv
// constants and carrier types for the remappable peripheral pin select block
// Functional notes
// R1: one input select register per peripheral input
// R2: inputs selected per peripheral, outputs per pin
// R3: input codes pick thirteen pins; some reserved
// R4: software avoids codes absent on small variants
// R5: input select keeps bits 3:0, rest zero
// R6: input select writes ignored while lock set
// R7: output select writes ignored while lock set
// R8: output select holds 4-bit code, resets zero
// R9: absent pins have no output select register
// R10: remapped peripheral has no default pin; input select reset code 0 selects pin 0 here
// R11: remapped output beats other digital pin functions
// R12: analog function always beats remapped peripheral
// R13: input and output mappings set independently
// R14: fixed-pin and analog modules never remapped
// R15: output code zero leaves pin to port
// R16: reserved or absent input code feeds idle
package rpps_pkg;
    localparam int SEL_W = 4;
    localparam int N_IN_FUNC = 8;
    localparam int N_OUT_PIN = 17;
    localparam int N_IN_PIN = 13;
    localparam int N_PERIPH_OUT = 15;
    localparam int LOCK_BIT = 13;
    localparam logic [3:0] SEL_RST = 4'h0;
    localparam logic LOCK_RST = 1'b0;
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_RSV_A = 4'hA;
    localparam logic [3:0] CODE_RSV_E = 4'hE;
    localparam logic [3:0] CODE_RSV_F = 4'hF;
    // register byte addresses
    localparam logic [15:0] CFG_CTRL_OFFS = 16'hF000;
    localparam logic [15:0] IN_SEL_OFFS [N_IN_FUNC] = '{
        16'hFA00, 16'hFA04, 16'hFA08, 16'hFA0C,
        16'hFA10, 16'hFA14, 16'hFA18, 16'hFA1C
    };
    localparam logic [15:0] OUT_SEL_OFFS [N_OUT_PIN] = '{
        16'hFB88, 16'hFB8C, 16'hFB90, 16'hFBB4, 16'hFBB8, 16'hFBC0,
        16'hFBC4, 16'hFBC8, 16'hFBCC, 16'hFBD0, 16'hFBD4, 16'hFBE0,
        16'hFBE4, 16'hFBE8, 16'hFBEC, 16'hFBF0, 16'hFBF8
    };
    // port-side control of the output-capable pins
    typedef struct packed {
        logic [N_OUT_PIN-1:0] gpio_out;
        logic [N_OUT_PIN-1:0] gpio_oe_n;
        logic [N_OUT_PIN-1:0] analog_en;
    } rpps_pin_ctl_s;
    // resolved drive of the output-capable pins
    typedef struct packed {
        logic [N_OUT_PIN-1:0] level;
        logic [N_OUT_PIN-1:0] oe_n;
    } rpps_pin_drv_s;
    // input-capable pins: sampled level and analog ownership
    typedef struct packed {
        logic [N_IN_PIN-1:0] level;
        logic [N_IN_PIN-1:0] analog_en;
    } rpps_in_pin_s;
endpackage

// ===== src/rpps_top.sv
// pin select register file, input muxing and output pin override
`timescale 1ns/100ps
module rpps_top
    import rpps_pkg::*;
#(
    // variant masks; a zero bit removes that pin
    parameter logic [N_OUT_PIN-1:0] OUT_PIN_PRESENT = 17'h1FFFF,
    parameter logic [N_IN_PIN-1:0] IN_PIN_PRESENT = 13'h1FFF,
    // level fed to a peripheral input that has no valid pin
    parameter logic [N_IN_FUNC-1:0] IN_IDLE_LEVEL = 8'h00
)
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // peripheral side
    output logic [N_IN_FUNC-1:0] PERIPH_IN,
    input wire logic [N_PERIPH_OUT-1:0] PERIPH_OUT,
    // pin side
    input wire rpps_in_pin_s IN_PINS,
    input wire rpps_pin_ctl_s PIN_CTL,
    output rpps_pin_drv_s PIN_DRV,
    // lock state for other register blocks
    output logic CFG_LOCKED
);

    // register state
    logic [SEL_W-1:0] in_sel_r [N_IN_FUNC];
    logic [SEL_W-1:0] out_sel_r [N_OUT_PIN];
    logic lock_r;
    logic [31:0] prdata_r;
    logic hit_r;
    logic [N_IN_FUNC-1:0] periph_in_r;
    logic [N_IN_FUNC-1:0] periph_in_nxt;
    rpps_pin_drv_s drv_r;
    rpps_pin_drv_s drv_nxt;

    // bus decode
    logic setup_ph;
    logic access_ph;
    logic wr_acc;
    logic in_hit;
    logic out_hit;
    logic cfg_hit;
    logic [2:0] in_idx;
    logic [4:0] out_idx;

    // index of the input select register at an address, with hit flag
    function automatic logic [3:0] in_decode(input logic [15:0] addr);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 0; i < N_IN_FUNC; i++)
        begin
            if (addr == IN_SEL_OFFS[i])
            begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    // index of the output select register; absent pins never hit
    function automatic logic [5:0] out_decode(input logic [15:0] addr);
        logic [5:0] res;
        res = 6'h00;
        for (int i = 0; i < N_OUT_PIN; i++)
        begin
            if (addr == OUT_SEL_OFFS[i] && OUT_PIN_PRESENT[i])
            begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction

    // input code to pin index; reserved code 1010 is skipped
    function automatic logic [4:0] code_to_pin(input logic [3:0] code);
        logic [4:0] res;
        res = 5'h1F;
        if (code < CODE_RSV_A)
        begin
            res = {1'b0, code};
        end
        else if (code > CODE_RSV_A && code < CODE_RSV_E)
        begin
            res = {1'b0, code - 4'h1};
        end
        return res;
    endfunction

    // decode of the current address
    always_comb
    begin
        logic [3:0] id;
        logic [5:0] od;
        id = in_decode(PADDR);
        od = out_decode(PADDR);
        in_hit = id[3];
        in_idx = id[2:0];
        out_hit = od[5];
        out_idx = od[4:0];
        cfg_hit = (PADDR == CFG_CTRL_OFFS);
    end

    assign setup_ph = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign wr_acc = access_ph && PWRITE && hit_r;
    // zero wait states: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = access_ph && !hit_r;
    assign PRDATA = prdata_r;
    assign CFG_LOCKED = lock_r;

    // read data and hit are captured in the setup cycle so that the
    // access phase sees flopped data without a wait state
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            prdata_r <= 32'h0000_0000;
            hit_r <= 1'b0;
        end
        else if (setup_ph)
        begin
            hit_r <= in_hit || out_hit || cfg_hit;
            prdata_r <= 32'h0000_0000;
            // R5: upper bits read zero
            if (in_hit)
            begin
                prdata_r[SEL_W-1:0] <= in_sel_r[in_idx];
            end
            // R8: output select upper bits zero
            else if (out_hit)
            begin
                prdata_r[SEL_W-1:0] <= out_sel_r[out_idx];
            end
            else if (cfg_hit)
            begin
                prdata_r[LOCK_BIT] <= lock_r;
            end
        end
    end

    // lock bit itself stays writable so software can reopen the map
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            lock_r <= LOCK_RST;
        end
        else if (wr_acc && cfg_hit)
        begin
            lock_r <= PWDATA[LOCK_BIT];
        end
    end

    // R1: one select field per peripheral input
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            for (int i = 0; i < N_IN_FUNC; i++)
            begin
                in_sel_r[i] <= SEL_RST;
            end
        end
        // R6: writes dropped while locked
        else if (wr_acc && in_hit && !lock_r)
        begin
            in_sel_r[in_idx] <= PWDATA[SEL_W-1:0];
        end
    end

    // R2: one select field per output pin
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            for (int i = 0; i < N_OUT_PIN; i++)
            begin
                out_sel_r[i] <= SEL_RST;
            end
        end
        // R7: writes dropped while locked
        // R9: absent pins never decode
        else if (wr_acc && out_hit && !lock_r)
        begin
            out_sel_r[out_idx] <= PWDATA[SEL_W-1:0];
        end
    end

    // input routing; a pin given to analog is never sampled for a peripheral
    always_comb
    begin
        logic [4:0] pin;
        pin = 5'h00;
        for (int f = 0; f < N_IN_FUNC; f++)
        begin
            pin = code_to_pin(in_sel_r[f]);
            // R16: reserved or absent pin feeds idle level
            periph_in_nxt[f] = IN_IDLE_LEVEL[f];
            // R3: thirteen distinct pins behind the codes
            // R12: analog owner keeps the pin
            if (pin < 5'(N_IN_PIN))
            begin
                if (IN_PIN_PRESENT[pin[3:0]] && !IN_PINS.analog_en[pin[3:0]])
                begin
                    periph_in_nxt[f] = IN_PINS.level[pin[3:0]];
                end
            end
        end
    end

    // output override, separate from the input map
    // R13: independent register sets
    always_comb
    begin
        logic [3:0] code;
        code = CODE_NONE;
        for (int p = 0; p < N_OUT_PIN; p++)
        begin
            code = out_sel_r[p];
            // R15: code zero leaves port control
            drv_nxt.level[p] = PIN_CTL.gpio_out[p];
            drv_nxt.oe_n[p] = PIN_CTL.gpio_oe_n[p];
            // R12: analog wins; R14: fixed functions untouched
            if (PIN_CTL.analog_en[p])
            begin
                drv_nxt.level[p] = 1'b0;
                drv_nxt.oe_n[p] = 1'b1;
            end
            // R11: remapped function beats digital port
            else if (code != CODE_NONE)
            begin
                drv_nxt.level[p] = PERIPH_OUT[code - 4'h1];
                drv_nxt.oe_n[p] = 1'b0;
            end
        end
    end

    // flopped outputs: one cycle from select or pin change to effect
    // R10: reset codes give no pin to any output; every peripheral input reads pin 0
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            periph_in_r <= IN_IDLE_LEVEL;
            drv_r.level <= '0;
            drv_r.oe_n <= '1;
        end
        else
        begin
            periph_in_r <= periph_in_nxt;
            drv_r <= drv_nxt;
        end
    end

    assign PERIPH_IN = periph_in_r;
    assign PIN_DRV = drv_r;

    // locked write leaves the input select unchanged
    lock_in_hold_a: assert property ( // R6
        @(posedge CORE_CLK) disable iff (RESET)
        (wr_acc && in_hit && lock_r) |=> in_sel_r[$past(in_idx)] == $past(in_sel_r[in_idx]))
        else $error("input select changed while locked");

    // locked write leaves the output select unchanged
    lock_out_hold_a: assert property ( // R7
        @(posedge CORE_CLK) disable iff (RESET)
        (wr_acc && out_hit && lock_r) |=> out_sel_r[$past(out_idx)] == $past(out_sel_r[out_idx]))
        else $error("output select changed while locked");

    // unlocked write lands low nibble next cycle
    in_sel_write_a: assert property ( // R1
        @(posedge CORE_CLK) disable iff (RESET)
        (wr_acc && in_hit && !lock_r)
            |=> in_sel_r[$past(in_idx)] == $past(PWDATA[3:0]))
        else $error("input select write lost");

    // completed read shows only the low field
    read_upper_zero_a: assert property ( // R5
        @(posedge CORE_CLK) disable iff (RESET)
        (access_ph && !PWRITE && hit_r && in_hit) |-> PRDATA[31:4] == 28'h0000000)
        else $error("input select read carried upper bits");

    // select reads never carry upper bits
    sel_upper_zero_a: assert property ( // R8
        @(posedge CORE_CLK) disable iff (RESET)
        (access_ph && hit_r && PADDR != CFG_CTRL_OFFS) |-> PRDATA[31:4] == 28'h0)
        else $error("select register upper bits not zero");

    // analog pins are released by the following cycle, whatever their code
    analog_release_a: assert property ( // R12
        @(posedge CORE_CLK) disable iff (RESET)
        (|PIN_CTL.analog_en)
            |=> ((PIN_DRV.oe_n & $past(PIN_CTL.analog_en)) == $past(PIN_CTL.analog_en))
                && ((PIN_DRV.level & $past(PIN_CTL.analog_en)) == 17'h00000))
        else $error("remap drove an analog pin");

    // nonzero code drives the pin from the peripheral
    remap_priority_a: assert property ( // R11
        @(posedge CORE_CLK) disable iff (RESET)
        (out_sel_r[0] != CODE_NONE && !PIN_CTL.analog_en[0])
            |=> !PIN_DRV.oe_n[0] && PIN_DRV.level[0] == $past(PERIPH_OUT[out_sel_r[0] - 4'h1]))
        else $error("remapped output lost priority");

    // zero code passes the port drive through
    zero_code_pass_a: assert property ( // R15
        @(posedge CORE_CLK) disable iff (RESET)
        (out_sel_r[0] == CODE_NONE && !PIN_CTL.analog_en[0])
            |=> PIN_DRV.oe_n[0] == $past(PIN_CTL.gpio_oe_n[0])
                && PIN_DRV.level[0] == $past(PIN_CTL.gpio_out[0]))
        else $error("port drive not passed through");

    // reserved code feeds the idle level
    reserved_idle_a: assert property ( // R16
        @(posedge CORE_CLK) disable iff (RESET)
        (in_sel_r[N_IN_FUNC-1] == CODE_RSV_A || in_sel_r[N_IN_FUNC-1] == CODE_RSV_E
            || in_sel_r[N_IN_FUNC-1] == CODE_RSV_F)
            |=> PERIPH_IN[N_IN_FUNC-1] == IN_IDLE_LEVEL[N_IN_FUNC-1])
        else $error("reserved input code not idle");

    // unmapped address answers with an error
    unmapped_err_a: assert property ( // R9
        @(posedge CORE_CLK) disable iff (RESET)
        (setup_ph && !in_hit && !out_hit && !cfg_hit) |=> (PENABLE |-> PSLVERR))
        else $error("unmapped access not flagged");

    // after reset output select 1 gives no pin away; input select 1 sits at code 0 (pin 0)
    reset_no_map_a: assert property ( // R10
        @(posedge CORE_CLK)
        $past(RESET) && !RESET |-> out_sel_r[1] == SEL_RST
            && in_sel_r[1] == SEL_RST)
        else $error("select not cleared by reset");

endmodule

// ===== sim/rpps_far_model.sv
// far-side model: peripheral output functions and remappable pin levels
`timescale 1ns/100ps
module rpps_far_model
    import rpps_pkg::*;
(
    // levels asked for by the bench
    input wire logic [N_IN_PIN-1:0] lvl,
    input wire logic [N_IN_PIN-1:0] ana,
    input wire logic [N_PERIPH_OUT-1:0] fn,
    // toward the block
    output rpps_in_pin_s pins,
    output logic [N_PERIPH_OUT-1:0] periph_out
);
    // levels follow the bench; the bench keeps to the code set of this variant
    // pins always carry a real level, so a wrong mux leg never reads as idle by luck
    assign pins = '{level: lvl, analog_en: ana};
    assign periph_out = fn;
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the pin select block over apb
`timescale 1ns/100ps
module tb_top;
    import rpps_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [15:0] padr = 16'h0000;
    logic [31:0] pwd = 32'h0000_0000;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic [N_IN_FUNC-1:0] pin_in;
    logic [N_IN_PIN-1:0] lvl = '0;
    logic [N_IN_PIN-1:0] ana = '0;
    logic [N_PERIPH_OUT-1:0] fn = '0;
    logic [N_PERIPH_OUT-1:0] pout;
    rpps_in_pin_s pins;
    rpps_pin_ctl_s ctl = '{gpio_out: '0, gpio_oe_n: '1, analog_en: '0};
    rpps_pin_drv_s drv;
    logic locked;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int samples_checked = 0;
    int idx;
    logic ok;

    rpps_far_model u_far (.lvl(lvl), .ana(ana), .fn(fn), .pins(pins), .periph_out(pout));
    rpps_top u_dut (
        .CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .PERIPH_IN(pin_in), .PERIPH_OUT(pout), .IN_PINS(pins), .PIN_CTL(ctl),
        .PIN_DRV(drv), .CFG_LOCKED(locked)
    );

    // clock of 100 ns period
    always #50 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    // one apb transfer; the answer is taken at the edge that samples pready high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (prdy !== 1'b1 && n < 50);
        // read before the flops update, so these are the values at this edge
        rd = prd;
        err = perr;
        if (prdy !== 1'b1)
        begin
            $display("MISMATCH pready expected 1 seen %b", prdy);
            bad_count++;
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // pin paths lag the register by an edge; look mid-cycle
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #(20000 * 100);
        bad_count++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < N_OUT_PIN; i++)
        begin
            apb(1'b0, OUT_SEL_OFFS[i], 32'h0);
            chk("out_sel reset", 32'h0, rd);
        end
        for (int i = 0; i < N_IN_FUNC; i++)
        begin
            apb(1'b0, IN_SEL_OFFS[i], 32'h0);
            chk("in_sel reset", 32'h0, rd);
        end
        settle();
        chk("periph_in idle", 32'h0, pin_in);
        chk("oe_n idle", 32'h1FFFF, drv.oe_n);
        // every input code on the last input; reserved codes must feed idle
        // full-pin variant, so codes 1000, 1001, 1011, 1100, 1101 are legal here
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, IN_SEL_OFFS[7], 32'hFFFF_FFF0 | c);
            apb(1'b0, IN_SEL_OFFS[7], 32'h0);
            chk("in_sel", c, rd);
            idx = (c < 10) ? c : c - 1;
            ok = (c != 10) && (c < 14);
            lvl <= ok ? (13'h0001 << idx) : 13'h1FFF;
            settle();
            chk("periph_in code", ok, pin_in[7]);
            chk("periph_in rsvd", ok, pin_in[7]);
            chk("periph_in others", lvl[0] ? 32'h7F : 32'h0, pin_in[6:0]);
        end
        // analog on the chosen input pin keeps it from the peripheral
        apb(1'b1, IN_SEL_OFFS[7], 32'hD);
        lvl <= 13'h1000;
        ana <= 13'h1000;
        settle();
        chk("periph_in analog", 32'h0, pin_in[7]);
        chk("out_sel apart", 32'h0, drv.oe_n[16] ^ 1'b1);
        // every output code on the last pin; port side asks for no drive
        for (int k = 0; k < 16; k++)
        begin
            apb(1'b1, OUT_SEL_OFFS[16], k);
            fn <= (k != 0) ? (15'h0001 << (k - 1)) : 15'h7FFF;
            settle();
            chk("pin level", k != 0, drv.level[16]);
            chk("pin oe_n", {k == 0, 16'hFFFF}, drv.oe_n);
        end
        @(posedge clk);
        ctl.analog_en[16] <= 1'b1;
        settle();
        chk("pin analog", 32'h1FFFF, drv.oe_n);
        chk("pin analog level", 32'h0, drv.level[16]);
        // lock blocks both select sets; unlock restores writes
        apb(1'b1, CFG_CTRL_OFFS, 32'h0000_2000);
        settle();
        chk("locked", 32'h1, locked);
        apb(1'b0, CFG_CTRL_OFFS, 32'h0);
        chk("cfg read", 32'h0000_2000, rd);
        apb(1'b1, IN_SEL_OFFS[0], 32'h3);
        apb(1'b0, IN_SEL_OFFS[0], 32'h0);
        chk("in_sel locked", 32'h0, rd);
        apb(1'b1, OUT_SEL_OFFS[0], 32'h5);
        apb(1'b0, OUT_SEL_OFFS[0], 32'h0);
        chk("out_sel locked", 32'h0, rd);
        apb(1'b1, CFG_CTRL_OFFS, 32'h0);
        apb(1'b1, OUT_SEL_OFFS[0], 32'h5);
        apb(1'b0, OUT_SEL_OFFS[0], 32'h0);
        chk("out_sel open", 32'h5, rd);
        chk("mapped error", 32'h0, err);
        // a hole between pin registers has no register behind it
        apb(1'b1, 16'hFBBC, 32'h7);
        apb(1'b0, 16'hFBBC, 32'h0);
        chk("hole data", 32'h0, rd);
        chk("hole error", 32'h1, err);
        conclude();
    end
endmodule
